// ===== verilog/ssr_readback.sv
`timescale 1ns/10ps
`include "ssr_consts.svh"
// Behaviour
// - msb echoes previous command's toggle bit
// - bit 14 set after undervoltage
// - bit 13 set after overvoltage
// - bits 12:8 echo previous select address
// - bits 7:4 per-output fault summaries
// - low nibble chosen by latest select
// - fault view: overtemp, high, low, open
// - fault pin flags all; all but open load latched until off
// - code 00001 returns serial on bits
// - code 01001 returns sense enable bits
// - suffix 010 returns trip levels
// - suffix 011 returns disables and blanking
// - suffix 100 returns direct input setup
// - code 00101 returns latch and voltage disables
// - code 01101 returns zero, expiry, period
// - expiry bit high only in fail-safe
// - code 00110 returns safe states, enable, wake
// - code 01110 returns direct pin levels
// - code 01111 returns high-pair latch settings
// - word shifts out msb first
// - only multiples of sixteen bits accepted
// - selection holds until next select write
module ssr_readback #(
    parameter int OUT_N = 4,
    parameter int WORD_W = `SSR_WORD_W
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_en_n,
    output logic o_fault_status_n,
    output logic [WORD_W-1:0] o_cmd_word,
    output logic o_cmd_valid,
    input wire logic i_undervoltage_event,
    input wire logic i_overvoltage_event,
    input wire logic i_wake_pin,
    input wire logic [3:0] i_direct_input_pin,
    input wire logic [15:0] i_fault_flags,
    input wire logic [3:0] i_serial_on_cmd,
    input wire logic [3:0] i_sense_enable_n,
    input wire logic [3:0] i_high_trip_level,
    input wire logic [3:0][2:0] i_low_trip_level,
    input wire logic [3:0] i_openload_disable,
    input wire logic [3:0] i_low_trip_disable,
    input wire logic [3:0][1:0] i_blanking_select,
    input wire logic [3:0] i_fast_slew,
    input wire logic [3:0] i_sense_ratio_high,
    input wire logic [3:0] i_direct_input_disable,
    input wire logic [3:0] i_and_combine,
    input wire logic [3:0] i_thermal_latch_disable,
    input wire logic i_undervoltage_disable,
    input wire logic i_overvoltage_disable,
    input wire logic i_watchdog_expired,
    input wire logic [1:0] i_watchdog_period_select,
    input wire logic i_output2_safe_state,
    input wire logic i_output0_safe_state,
    input wire logic i_watchdog_enabled
);
    // the nibble mapping is fixed to four outputs and a 16-bit word
    generate
        if (OUT_N != 4 || WORD_W != 16) begin : g_bad_size
            $error("ssr_readback supports only four outputs and a 16-bit word");
        end
    endgenerate

    // ---------------- pin synchronisers (mclk) ----------------
    logic [`SSR_PIN_W-1:0] pin_meta_q;
    logic [`SSR_PIN_W-1:0] pin_meta_d;
    logic [`SSR_PIN_W-1:0] pin_sync_q;
    logic [`SSR_PIN_W-1:0] pin_sync_d;
    logic cs_sync;
    logic uv_sync;
    logic ov_sync;
    logic wake_sync;
    logic [3:0] dir_sync;
    logic [15:0] flt_sync;

    // first stage feeds only the second stage
    always_comb begin
        pin_meta_d = {i_undervoltage_event, i_overvoltage_event, i_wake_pin, i_direct_input_pin, i_fault_flags, i_cs_n};
        pin_sync_d = pin_meta_q;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            pin_meta_q <= {{(`SSR_PIN_W-1){1'b0}}, 1'b1};
            pin_sync_q <= {{(`SSR_PIN_W-1){1'b0}}, 1'b1};
        end else if (i_ce) begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    assign cs_sync = pin_sync_q[0];
    assign flt_sync = pin_sync_q[16:1];
    assign dir_sync = pin_sync_q[20:17];
    assign wake_sync = pin_sync_q[21];
    assign ov_sync = pin_sync_q[22];
    assign uv_sync = pin_sync_q[23];

    // ---------------- per-output fault latches ----------------
    logic [3:0] on_prev_q;
    logic [3:0] dir_prev_q;
    logic [3:0] fault_sum;
    logic [3:0] alarm_vec;
    ssr_pkg::ssr_flags_t [3:0] view_vec;

    // switch-off is a falling serial on bit or a falling direct pin
    generate
        for (genvar k = 0; k < 4; k++) begin : g_out
            ssr_fault_if fif ();
            assign fif.flags_live = ssr_pkg::ssr_flags_t'(flt_sync[4*k+3:4*k]);
            assign fif.overtemp_latch_en = ~i_thermal_latch_disable[k];
            assign fif.switch_off = (on_prev_q[k] & ~i_serial_on_cmd[k]) | (dir_prev_q[k] & ~dir_sync[k]);
            assign view_vec[k] = fif.flags_view;
            assign fault_sum[k] = |fif.flags_view;
            assign alarm_vec[k] = fif.alarm;
            ssr_fault_latch u_latch (
                .i_mclk(i_mclk),
                .i_rstn(i_rstn),
                .i_ce(i_ce),
                .fif(fif.latch)
            );
        end
    endgenerate

    // ---------------- status word assembly ----------------
    logic [4:0] sel_q;
    logic [4:0] sel_d;
    logic toggle_q;
    logic toggle_d;
    logic uv_q;
    logic uv_d;
    logic ov_q;
    logic ov_d;
    logic primed_q;
    logic primed_d;
    logic [3:0] low_nib;
    logic [WORD_W-1:0] status_word;
    logic [1:0] out_idx;
    ssr_pkg::ssr_view_t view_code;

    assign out_idx = sel_q[4:3];
    assign view_code = ssr_pkg::ssr_view_t'(sel_q[2:0]);

    // whole codes first, then the per-output views by suffix
    always_comb begin
        low_nib = 4'h0;
        case (sel_q)
            `SSR_SEL_ON_CMD: begin
                low_nib = i_serial_on_cmd;
            end
            `SSR_SEL_SENSE_EN: begin
                low_nib = i_sense_enable_n;
            end
            `SSR_SEL_VOLT_CTRL: begin
                low_nib = {i_thermal_latch_disable[1], i_thermal_latch_disable[0],
                           i_undervoltage_disable, i_overvoltage_disable};
            end
            `SSR_SEL_WDOG: begin
                // expiry input is high only in fail-safe mode
                low_nib = {1'b0, i_watchdog_expired, i_watchdog_period_select};
            end
            `SSR_SEL_SAFE_PINS: begin
                low_nib = {i_output2_safe_state, i_output0_safe_state, i_watchdog_enabled, wake_sync};
            end
            `SSR_SEL_DIRECT_PINS: begin
                low_nib = dir_sync;
            end
            `SSR_SEL_HIGH_LATCH: begin
                // low two bits are don't-care; zero keeps them stable
                low_nib = {i_thermal_latch_disable[3], i_thermal_latch_disable[2], 2'b00};
            end
            default: begin
                case (view_code)
                    ssr_pkg::SSR_VIEW_FAULT: begin
                        low_nib = view_vec[out_idx];
                    end
                    ssr_pkg::SSR_VIEW_LEVELS: begin
                        low_nib = {i_high_trip_level[out_idx], i_low_trip_level[out_idx]};
                    end
                    ssr_pkg::SSR_VIEW_BLANK: begin
                        low_nib = {i_openload_disable[out_idx], i_low_trip_disable[out_idx],
                                   i_blanking_select[out_idx]};
                    end
                    ssr_pkg::SSR_VIEW_DIRECT: begin
                        low_nib = {i_fast_slew[out_idx], i_sense_ratio_high[out_idx],
                                   i_direct_input_disable[out_idx], i_and_combine[out_idx]};
                    end
                    default: begin
                        low_nib = 4'h0;
                    end
                endcase
            end
        endcase
        status_word = `SSR_WORD_RST;
        if (primed_q) begin
            status_word[`SSR_BIT_TOGGLE] = toggle_q;
            status_word[`SSR_BIT_UNDERV] = uv_q;
            status_word[`SSR_BIT_OVERV] = ov_q;
            status_word[`SSR_ECHO_MSB:`SSR_ECHO_LSB] = sel_q;
            status_word[`SSR_SUM_MSB:`SSR_SUM_LSB] = fault_sum;
            status_word[3:0] = low_nib;
        end
    end

    // ---------------- link side (sclk) ----------------
    logic seq_q;
    logic [WORD_W-1:0] tx_word_q;
    logic last_seq_q;
    logic last_seq_d;
    logic [`SSR_CNT_W-1:0] cnt_q;
    logic [`SSR_CNT_W-1:0] cnt_d;
    logic full_q;
    logic full_d;
    logic [WORD_W-1:0] rx_q;
    logic [WORD_W-1:0] rx_d;
    logic so_q;
    logic so_d;
    logic first_edge;

    // seq_q and tx_word_q are quiet for the whole frame, so
    // the link side may read them without a synchroniser
    assign first_edge = (seq_q != last_seq_q);

    // after sixteen bits the word received sixteen edges ago follows
    always_comb begin
        rx_d = {rx_q[WORD_W-2:0], i_si};
        last_seq_d = seq_q;
        if (first_edge) begin
            cnt_d = `SSR_CNT_W'(1);
            full_d = 1'b0;
        end else begin
            cnt_d = cnt_q + `SSR_CNT_W'(1);
            full_d = full_q | (cnt_q == {`SSR_CNT_W{1'b1}});
        end
        so_d = full_d ? rx_d[WORD_W-1] : tx_word_q[{`SSR_CNT_W{1'b1}} - cnt_d];
    end

    // link reset needs sclk edges while reset is held
    always_ff @(posedge i_sclk) begin
        if (!i_rstn) begin
            last_seq_q <= 1'b0;
            cnt_q <= '0;
            full_q <= 1'b0;
            rx_q <= '0;
            so_q <= 1'b0;
        end else begin
            last_seq_q <= last_seq_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            rx_q <= rx_d;
            so_q <= so_d;
        end
    end

    // msb is on the pin before the first edge of the frame
    assign o_so = first_edge ? tx_word_q[WORD_W-1] : so_q;

    // ---------------- frame control (mclk) ----------------
    logic cs_prev_q;
    logic cs_prev_d;
    logic seq_d;
    logic [WORD_W-1:0] tx_word_d;
    logic [WORD_W-1:0] cmd_word_q;
    logic [WORD_W-1:0] cmd_word_d;
    logic cmd_valid_q;
    logic cmd_valid_d;
    logic so_en_n_q;
    logic so_en_n_d;
    logic fault_n_q;
    logic fault_n_d;
    logic [3:0] on_prev_d;
    logic [3:0] dir_prev_d;
    logic cs_fall;
    logic cs_rise;
    logic frame_ok;

    assign cs_fall = cs_prev_q & ~cs_sync;
    assign cs_rise = ~cs_prev_q & cs_sync;
    // link registers are still once select is high again
    assign frame_ok = cs_rise && (last_seq_q == seq_q) && (cnt_q == '0) && full_q;

    always_comb begin
        cs_prev_d = cs_sync;
        seq_d = seq_q;
        tx_word_d = tx_word_q;
        cmd_word_d = cmd_word_q;
        cmd_valid_d = 1'b0;
        toggle_d = toggle_q;
        sel_d = sel_q;
        primed_d = primed_q;
        // events set, a valid frame clears; set wins
        uv_d = uv_sync | (uv_q & ~frame_ok);
        ov_d = ov_sync | (ov_q & ~frame_ok);
        so_en_n_d = cs_sync;
        fault_n_d = ~|alarm_vec;
        on_prev_d = i_serial_on_cmd;
        dir_prev_d = dir_sync;
        if (cs_fall) begin
            // restart from the link's phase: an edgeless frame leaves no skew
            seq_d = ~last_seq_q;
            tx_word_d = status_word;
        end
        // short or unclocked frames leave every field untouched
        if (frame_ok) begin
            cmd_word_d = rx_q;
            cmd_valid_d = 1'b1;
            primed_d = 1'b1;
            toggle_d = rx_q[`SSR_CMD_TOGGLE];
            if (rx_q[`SSR_CMD_REG_MSB:`SSR_CMD_REG_LSB] == `SSR_REG_STATUS_SEL) begin
                sel_d = rx_q[`SSR_CMD_SEL_MSB:`SSR_CMD_SEL_LSB];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cs_prev_q <= 1'b1;
            seq_q <= 1'b0;
            tx_word_q <= `SSR_WORD_RST;
            cmd_word_q <= `SSR_WORD_RST;
            cmd_valid_q <= 1'b0;
            toggle_q <= 1'b0;
            sel_q <= '0;
            primed_q <= 1'b0;
            uv_q <= 1'b0;
            ov_q <= 1'b0;
            so_en_n_q <= 1'b1;
            fault_n_q <= 1'b1;
            on_prev_q <= '0;
            dir_prev_q <= '0;
        end else if (i_ce) begin
            cs_prev_q <= cs_prev_d;
            seq_q <= seq_d;
            tx_word_q <= tx_word_d;
            cmd_word_q <= cmd_word_d;
            cmd_valid_q <= cmd_valid_d;
            toggle_q <= toggle_d;
            sel_q <= sel_d;
            primed_q <= primed_d;
            uv_q <= uv_d;
            ov_q <= ov_d;
            so_en_n_q <= so_en_n_d;
            fault_n_q <= fault_n_d;
            on_prev_q <= on_prev_d;
            dir_prev_q <= dir_prev_d;
        end
    end

    assign o_so_en_n = so_en_n_q;
    assign o_fault_status_n = fault_n_q;
    assign o_cmd_word = cmd_word_q;
    assign o_cmd_valid = cmd_valid_q;
endmodule

// ===== shared/ssr_consts.svh
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// return word layout
`define SSR_WORD_W 16
`define SSR_WORD_RST 16'h0000
`define SSR_BIT_TOGGLE 15
`define SSR_BIT_UNDERV 14
`define SSR_BIT_OVERV 13
`define SSR_ECHO_MSB 12
`define SSR_ECHO_LSB 8
`define SSR_SUM_MSB 7
`define SSR_SUM_LSB 4

// incoming command word fields
`define SSR_CMD_TOGGLE 15
`define SSR_CMD_REG_MSB 10
`define SSR_CMD_REG_LSB 8
`define SSR_CMD_SEL_MSB 4
`define SSR_CMD_SEL_LSB 0
`define SSR_REG_STATUS_SEL 3'h0

// whole-code selections that are not output specific
`define SSR_SEL_ON_CMD 5'h01
`define SSR_SEL_SENSE_EN 5'h09
`define SSR_SEL_VOLT_CTRL 5'h05
`define SSR_SEL_WDOG 5'h0D
`define SSR_SEL_SAFE_PINS 5'h06
`define SSR_SEL_DIRECT_PINS 5'h0E
`define SSR_SEL_HIGH_LATCH 5'h0F

// synchroniser and counter sizing
`define SSR_PIN_W 24
`define SSR_CNT_W 4

`endif

// ===== shared/ssr_pkg.sv
package ssr_pkg;

    // low three select bits of an output-specific view
    typedef enum logic [2:0] {
        SSR_VIEW_FAULT = 3'b000,
        SSR_VIEW_LEVELS = 3'b010,
        SSR_VIEW_BLANK = 3'b011,
        SSR_VIEW_DIRECT = 3'b100
    } ssr_view_t;

    // fault flag order inside one output's nibble
    typedef struct packed {
        logic overtemp;
        logic trip_high;
        logic trip_low;
        logic open_load;
    } ssr_flags_t;

endpackage

// ===== shared/ssr_fault_if.sv
`timescale 1ns/10ps
interface ssr_fault_if;
    ssr_pkg::ssr_flags_t flags_live;
    logic overtemp_latch_en;
    logic switch_off;
    ssr_pkg::ssr_flags_t flags_view;
    logic alarm;

    modport owner (
        output flags_live,
        output overtemp_latch_en,
        output switch_off,
        input flags_view,
        input alarm
    );
    modport latch (
        input flags_live,
        input overtemp_latch_en,
        input switch_off,
        output flags_view,
        output alarm
    );
endinterface

// ===== verilog/ssr_fault_latch.sv
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_fault_latch (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    ssr_fault_if.latch fif
);
    ssr_pkg::ssr_flags_t held_q;
    ssr_pkg::ssr_flags_t held_d;
    ssr_pkg::ssr_flags_t latchable;

    // open load never latches; overtemp latches unless disabled
    always_comb begin
        latchable = '{overtemp: fif.overtemp_latch_en, trip_high: 1'b1, trip_low: 1'b1, open_load: 1'b0};
        // set wins over the switch-off clear
        held_d = (held_q & ~{4{fif.switch_off}}) | (fif.flags_live & latchable);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            held_q <= '0;
        end else if (i_ce) begin
            held_q <= held_d;
        end
    end

    // live faults show at once, latched ones stay until switched off
    assign fif.flags_view = held_q | fif.flags_live;
    assign fif.alarm = |(held_q | fif.flags_live);
endmodule

// ===== tb/ssr_checker.sv
`timescale 1ns/10ps
// pin-level watch of the readback block, system clock domain only
module ssr_checker #(
    parameter int WORD_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic [15:0] i_fault_flags,
    input wire logic o_so_en_n,
    input wire logic o_fault_status_n,
    input wire logic [WORD_W-1:0] o_cmd_word,
    input wire logic o_cmd_valid
);
    logic any_flt;

    // collapse the flags so $past sees a plain signal
    assign any_flt = |i_fault_flags;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    // fault present long enough to pass the synchroniser
    sequence flt_held;
        any_flt [*5];
    endsequence
    // strobe lasting exactly one cycle
    sequence one_pulse;
        o_cmd_valid ##1 !o_cmd_valid;
    endsequence

    valid_after_end_a: assert property (o_cmd_valid |-> $past(i_cs_n, 1) && $past(i_cs_n, 2))
        else $error("command strobe while selected");
    valid_single_a: assert property ($rose(o_cmd_valid) |-> one_pulse)
        else $error("command strobe longer than one cycle");
    word_hold_a: assert property (!$stable(o_cmd_word) |-> o_cmd_valid)
        else $error("command word moved without strobe");
    drive_in_frame_a: assert property ($fell(o_so_en_n) |-> !$past(i_cs_n, 1) && !$past(i_cs_n, 2))
        else $error("serial out driven while deselected");
    release_after_a: assert property ($rose(o_so_en_n) |-> $past(i_cs_n, 1) && $past(i_cs_n, 2))
        else $error("serial out released while selected");
    quiet_on_valid_a: assert property (o_cmd_valid |-> o_so_en_n)
        else $error("serial out still driven at frame end");
    reset_clear_a: assert property ($rose(i_rstn) |-> !(|o_cmd_word) && !o_cmd_valid && o_so_en_n)
        else $error("outputs not cleared by reset");
    fault_pin_a: assert property (flt_held |-> !o_fault_status_n)
        else $error("fault pin missed a fault");
    fault_cause_a: assert property ($fell(o_fault_status_n) |->
        $past(any_flt, 2) || $past(any_flt, 3) || $past(any_flt, 4))
        else $error("fault pin fell without a fault");
endmodule

bind ssr_readback ssr_checker #(.WORD_W(WORD_W)) u_chk (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_fault_flags(i_fault_flags),
    .o_so_en_n(o_so_en_n), .o_fault_status_n(o_fault_status_n), .o_cmd_word(o_cmd_word),
    .o_cmd_valid(o_cmd_valid));

// ===== tb/ssr_host.sv
`timescale 1ns/10ps
// serial bus master; its clock idles low and runs only inside frames and in reset_clocks
module ssr_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_si = 1'h0;
    end

    // two link edges with select high so the link registers reset
    task automatic reset_clocks();
        repeat (2) begin
            #40 o_sclk = 1'h1;
            #40 o_sclk = 1'h0;
        end
    endtask

    // n-bit frame msb first; reply bits are taken just before each rise
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        o_cs_n = 1'h0;
        #300;
        for (int i = n - 1; i >= 0; i--) begin
            o_si = tx[i];
            #40 rx = {rx[30:0], i_so};
            o_sclk = 1'h1;
            #40 o_sclk = 1'h0;
        end
        o_cs_n = 1'h1;
        o_si = ~o_si; // a released line keeps no value
        #400;
    endtask
endmodule

// ===== tb/ssr_readback_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, s); end end
module ssr_readback_tb;
    logic i_mclk, i_rstn, sclk, cs_n, si, so, so_en_n, fs_n, cv, ce;
    logic uv, ov, wake, tud, tod, wdx, s2, s0, wde, eu, eo, tog_m;
    logic [3:0] din, on, sen_n, hi, old, ltd, fst, rat, dd, anc, tld;
    logic [3:0][2:0] lo;
    logic [3:0][1:0] blk;
    logic [1:0] wdp;
    logic [15:0] cw, flt, fv, c;
    logic [31:0] rx;
    logic [4:0] sel_m;
    logic [63:0] r;
    int err_total, samples_checked, vcnt;
    int bad[3] = '{15, 17, 0};
    logic [4:0] wc[7] = '{5'h01, 5'h09, 5'h05, 5'h0D, 5'h06, 5'h0E, 5'h0F};

    ssr_readback u_dut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(ce), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_en_n(so_en_n), .o_fault_status_n(fs_n), .o_cmd_word(cw), .o_cmd_valid(cv),
        .i_undervoltage_event(uv), .i_overvoltage_event(ov), .i_wake_pin(wake), .i_direct_input_pin(din),
        .i_fault_flags(flt), .i_serial_on_cmd(on), .i_sense_enable_n(sen_n), .i_high_trip_level(hi),
        .i_low_trip_level(lo), .i_openload_disable(old), .i_low_trip_disable(ltd), .i_blanking_select(blk),
        .i_fast_slew(fst), .i_sense_ratio_high(rat), .i_direct_input_disable(dd), .i_and_combine(anc),
        .i_thermal_latch_disable(tld), .i_undervoltage_disable(tud), .i_overvoltage_disable(tod),
        .i_watchdog_expired(wdx), .i_watchdog_period_select(wdp), .i_output2_safe_state(s2),
        .i_output0_safe_state(s0), .i_watchdog_enabled(wde));
    ssr_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));

    // 20 MHz system clock
    initial begin
        i_mclk = 1'h0;
        forever #25 i_mclk = ~i_mclk;
    end

    // counts command strobes for the length checks
    always @(negedge i_mclk) begin
        if (cv === 1'h1) vcnt++;
    end

    // codes with a defined low nibble; others are left alone
    function automatic bit ok(input logic [4:0] s);
        return s[2:0] inside {3'h0, 3'h2, 3'h3, 3'h4} || s inside {5'h01, 5'h09, 5'h05, 5'h0D, 5'h06, 5'h0E, 5'h0F};
    endfunction

    // low nibble for a selection, from the driven inputs
    function automatic logic [3:0] nib(input logic [4:0] s);
        int k;
        k = int'(s[4:3]);
        case (s[2:0])
            3'h0: return fv[4*k +: 4];
            3'h2: return {hi[k], lo[k]};
            3'h3: return {old[k], ltd[k], blk[k]};
            3'h4: return {fst[k], rat[k], dd[k], anc[k]};
            default: case (s)
                5'h01: return on;
                5'h09: return sen_n;
                5'h05: return {tld[1:0], tud, tod};
                5'h0D: return {1'h0, wdx, wdp};
                5'h06: return {s2, s0, wde, wake};
                5'h0E: return din;
                default: return {tld[3:2], 2'h0};
            endcase
        endcase
    endfunction

    function automatic logic [15:0] expw(input logic u, input logic o);
        return {tog_m, u, o, sel_m, |fv[15:12], |fv[11:8], |fv[7:4], |fv[3:0], nib(sel_m)};
    endfunction

    // all configuration drawn at once; wide draw sliced to fit
    task automatic rnd();
        r = {$urandom, $urandom};
        {on, sen_n, hi, old, ltd, fst, rat, dd, anc, tld, din} = r[43:0];
        r = {$urandom, $urandom};
        {lo, blk, wdp, tud, tod, wdx, s2, s0, wde, wake} = r[28:0];
    endtask

    // one frame, reply and strobe checked, model updated only when accepted
    task automatic frame(input logic [31:0] tx, input int n, input logic [15:0] e);
        int v0;
        v0 = vcnt;
        @(negedge i_mclk);
        #7;
        u_host.xfer(tx, n, rx);
        if (n >= 16) `CHK("word", e, rx[n-1 -: 16])
        if (n == 32) `CHK("chain", tx[31:16], rx[15:0])
        `CHK("strobe", (n > 0 && n % 16 == 0), (vcnt == v0 + 1))
        if (n > 0 && n % 16 == 0) begin
            `CHK("cmd", tx[15:0], cw)
            tog_m = tx[15];
            if (tx[10:8] == 3'h0) sel_m = tx[4:0];
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #2000000;
        err_total++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        {i_rstn, uv, ov, tog_m, sel_m, flt, fv} = '0;
        ce = 1'h1;
        void'($urandom(94));
        rnd();
        u_host.reset_clocks();
        repeat (20) @(negedge i_mclk);
        i_rstn = 1'h1;
        repeat (4) @(negedge i_mclk);
        frame(32'h0000_800A, 16, 16'h0000);
        // random selections, echoes and sticky voltage events; early even
        // passes walk every whole-code view, each read back one frame later
        for (int t = 0; t < 40; t++) begin
            @(negedge i_mclk);
            rnd();
            {uv, ov} = 2'($urandom);
            {eu, eo} = {uv, ov};
            repeat (4) @(negedge i_mclk);
            {uv, ov} = 2'h0;
            c = 16'($urandom);
            if (t % 2 == 0) c[10:8] = 3'h0;
            if (!ok(c[4:0])) c[4:0] = 5'h0E;
            if (t < 14 && t % 2 == 0) c[4:0] = wc[t / 2];
            frame({16'h0, c}, 16, expw(eu, eo));
        end
        // refused lengths leave every field and the sticky flag alone;
        // the edgeless frame is last so that a valid frame follows it
        uv = 1'h1;
        repeat (4) @(negedge i_mclk);
        uv = 1'h0;
        foreach (bad[i]) frame(32'h0000_8001, bad[i], expw(1'h1, 1'h0));
        frame(32'h1234_8005, 32, expw(1'h1, 1'h0));
        frame(32'h0000_0010, 16, expw(1'h0, 1'h0));
        // stalled clock enable: an event seen only while frozen is lost
        @(negedge i_mclk);
        ce = 1'h0;
        uv = 1'h1;
        repeat (4) @(negedge i_mclk);
        uv = 1'h0;
        repeat (2) @(negedge i_mclk);
        ce = 1'h1;
        // latched faults survive readback until the output is switched off
        on = 4'hF;
        tld = 4'h0;
        flt = 16'h0F00;
        fv = 16'h0F00;
        repeat (10) @(negedge i_mclk);
        `CHK("fs_live", 1'h0, fs_n)
        frame(32'h0000_0010, 16, expw(1'h0, 1'h0));
        flt = 16'h0;
        fv = 16'h0E00;
        repeat (10) @(negedge i_mclk);
        frame(32'h0000_0010, 16, expw(1'h0, 1'h0));
        `CHK("fs_held", 1'h0, fs_n)
        on = 4'hB;
        fv = 16'h0;
        repeat (10) @(negedge i_mclk);
        `CHK("fs_clear", 1'h1, fs_n)
        frame(32'h0000_0010, 16, expw(1'h0, 1'h0));
        tally_and_finish();
    end
endmodule
